/* File: common/tmr8_pkg.sv */
// Shared constants and types of the dual-channel 8-bit timer.
// Assumes a single 200 MHz system clock and an AHB-Lite register bus.
package tmr8_pkg;
    // ==========================================================
    // Geometry
    localparam int TMR8_NCH = 2;
    localparam int TMR8_DIV_W = 11;
    // ==========================================================
    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_SHARED_SERIAL_TIMER_CONTROL = 16'hFFC3;
    localparam logic [15:0] IDX_CTRL [TMR8_NCH] = '{16'hFFC8, 16'hFFD0};
    localparam logic [15:0] IDX_CSR [TMR8_NCH] = '{16'hFFC9, 16'hFFD1};
    localparam logic [15:0] IDX_TCA [TMR8_NCH] = '{16'hFFCA, 16'hFFD2};
    localparam logic [15:0] IDX_TCB [TMR8_NCH] = '{16'hFFCB, 16'hFFD3};
    localparam logic [15:0] IDX_CNT [TMR8_NCH] = '{16'hFFCC, 16'hFFD4};
    // ==========================================================
    // Reset values, counter maximum and step
    localparam logic [7:0] SHARED_SERIAL_TIMER_CONTROL_RST = 8'h1C;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CSR_RST = 8'h00;
    localparam logic [7:0] TC_RST = 8'hFF;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_STEP = 8'h01;
    // ==========================================================
    // Field positions
    localparam int CTRL_IE_B = 7;
    localparam int CTRL_IE_A = 6;
    localparam int CTRL_IE_OV = 5;
    localparam int CTRL_CLR_HI = 4;
    localparam int CTRL_CLR_LO = 3;
    localparam int CTRL_CKS_HI = 2;
    localparam int CSR_FB = 7;
    localparam int CSR_FA = 6;
    localparam int CSR_OVF = 5;
    localparam int CSR_PWM = 4;
    localparam int CSR_OSB_HI = 3;
    localparam int CSR_OSB_LO = 2;
    localparam int CSR_OSA_HI = 1;
    localparam int CSR_OSA_LO = 0;
    // Prescaler tap bit for each internal divide ratio
    localparam int TAP_D2 = 0;
    localparam int TAP_D8 = 2;
    localparam int TAP_D32 = 4;
    localparam int TAP_D64 = 5;
    localparam int TAP_D128 = 6;
    localparam int TAP_D256 = 7;
    localparam int TAP_D1024 = 9;
    localparam int TAP_D2048 = 10;
    // ==========================================================
    // Bus encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam int HTRANS_ACTIVE = 1;
    // ==========================================================
    // Enumerations
    typedef enum logic [1:0] {
        CLR_NONE = 2'h0, CLR_MATCH_A = 2'h1, CLR_MATCH_B = 2'h2, CLR_EXT = 2'h3
    } tmr8_clr_t;
    typedef enum logic [2:0] {
        CKS_STOP = 3'h0, CKS_INT1 = 3'h1, CKS_INT2 = 3'h2, CKS_INT3 = 3'h3,
        CKS_STOP2 = 3'h4, CKS_EXT_RISE = 3'h5, CKS_EXT_FALL = 3'h6, CKS_EXT_BOTH = 3'h7
    } tmr8_cks_t;
    typedef enum logic [1:0] {
        OUT_KEEP = 2'h0, OUT_LOW = 2'h1, OUT_HIGH = 2'h2, OUT_TOGGLE = 2'h3
    } tmr8_out_t;
    typedef enum logic [2:0] {
        REG_NONE = 3'h0, REG_SHARED_SERIAL_TIMER_CONTROL = 3'h1, REG_CTRL = 3'h2, REG_CSR = 3'h3,
        REG_TCA = 3'h4, REG_TCB = 3'h5, REG_CNT = 3'h6
    } tmr8_reg_t;
    typedef struct packed {
        tmr8_reg_t kind;
        logic ch;
    } tmr8_dec_t;
endpackage

/* File: common/tmr8_div_if.sv */
// Carries the free-running prescaler value to the channel logic.
// Assumes producer and consumer share clk_sys.
`timescale 1ns/1ps
interface tmr8_div_if import tmr8_pkg::*; #(parameter int DIV_W = TMR8_DIV_W) ();
    logic [DIV_W-1:0] taps;
    modport src (output taps);
    modport snk (input taps);
endinterface

/* File: core/tmr8_prescaler.sv */
// Free-running divider of the system clock; each bit is one internal clock.
// Assumes a consumer that looks for falling edges of the chosen bit.
`timescale 1ns/1ps
module tmr8_prescaler import tmr8_pkg::*; #(
    parameter int DIV_W = TMR8_DIV_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    tmr8_div_if.src div_if
);
    // ==========================================================
    // Elaboration check
    if (DIV_W < TMR8_DIV_W) begin : g_bad_width
        $error("prescaler narrower than the slowest internal clock");
    end

    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] next_div;

    // Bit k toggles at clk_sys / 2^(k+1)
    always_comb begin
        next_div = DIV_W'(div + 1'b1);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div <= '0;
        end else begin
            div <= next_div;
        end
    end

    // Taps straight from the flops, so every level is glitch free
    assign div_if.taps = div;
endmodule

/* File: core/tmr8_top.sv */
// Dual-channel 8-bit timer with an AHB-Lite register slave.
// Assumes timer pins are asynchronous and standby comes from clk_sys logic.
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
module tmr8_top import tmr8_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic standby,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [TMR8_NCH-1:0] external_count_clock_pin,
    input wire logic [TMR8_NCH-1:0] external_counter_reset_pin,
    output logic [TMR8_NCH-1:0] timer_output_pin,
    output logic [TMR8_NCH-1:0] match_a_irq,
    output logic [TMR8_NCH-1:0] match_b_irq,
    output logic [TMR8_NCH-1:0] overflow_irq
);
    // ==========================================================
    // Functions

    // Map a byte address onto a register; upper bits must be zero
    function automatic tmr8_dec_t tmr8_decode(input logic [31:0] a);
        tmr8_dec_t d;
        d = '{kind: REG_NONE, ch: 1'b0};
        if (a[31:18] == 14'h0000) begin
            if (a[17:2] == IDX_SHARED_SERIAL_TIMER_CONTROL) begin
                d.kind = REG_SHARED_SERIAL_TIMER_CONTROL;
            end
            for (int c = 0; c < TMR8_NCH; c++) begin
                if (a[17:2] == IDX_CTRL[c]) d = '{kind: REG_CTRL, ch: 1'(c)};
                if (a[17:2] == IDX_CSR[c]) d = '{kind: REG_CSR, ch: 1'(c)};
                if (a[17:2] == IDX_TCA[c]) d = '{kind: REG_TCA, ch: 1'(c)};
                if (a[17:2] == IDX_TCB[c]) d = '{kind: REG_TCB, ch: 1'(c)};
                if (a[17:2] == IDX_CNT[c]) d = '{kind: REG_CNT, ch: 1'(c)};
            end
        end
        return d;
    endfunction

    // Level of the chosen internal clock, low when none is chosen
    function automatic logic tmr8_int_level(input logic ch, input logic [2:0] cks,
            input logic refine, input logic [TMR8_DIV_W-1:0] taps);
        logic lvl;
        lvl = 1'b0;
        case (tmr8_cks_t'(cks))
            CKS_INT1: lvl = refine ? taps[TAP_D2] : taps[TAP_D8];
            CKS_INT2: lvl = refine ? (ch ? taps[TAP_D128] : taps[TAP_D32]) : taps[TAP_D64];
            CKS_INT3: lvl = refine ? (ch ? taps[TAP_D2048] : taps[TAP_D256])
                                   : taps[TAP_D1024];
            default: lvl = 1'b0;
        endcase
        return lvl;
    endfunction

    // Apply one compare-match action to the output level
    function automatic logic tmr8_apply(input logic cur, input logic [1:0] act);
        logic res;
        res = cur;
        case (tmr8_out_t'(act))
            OUT_KEEP: res = cur;
            OUT_LOW: res = 1'b0;
            OUT_HIGH: res = 1'b1;
            OUT_TOGGLE: res = ~cur;
            default: res = cur;
        endcase
        return res;
    endfunction

    // ==========================================================
    // Prescaler
    tmr8_div_if #(.DIV_W(TMR8_DIV_W)) div_bus ();

    tmr8_prescaler #(.DIV_W(TMR8_DIV_W)) u_prescaler (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .div_if(div_bus)
    );

    // ==========================================================
    // Pin synchronisers (third stage only feeds the edge detectors)
    logic [TMR8_NCH-1:0] ck_s1, ck_s2, ck_s3;
    logic [TMR8_NCH-1:0] rs_s1, rs_s2, rs_s3;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ck_s1 <= '0;
            ck_s2 <= '0;
            ck_s3 <= '0;
            rs_s1 <= '0;
            rs_s2 <= '0;
            rs_s3 <= '0;
        end else begin
            ck_s1 <= external_count_clock_pin;
            ck_s2 <= ck_s1;
            ck_s3 <= ck_s2;
            rs_s1 <= external_counter_reset_pin;
            rs_s2 <= rs_s1;
            rs_s3 <= rs_s2;
        end
    end

    // ==========================================================
    // Bus slave state
    logic ap_valid, ap_write;
    tmr8_dec_t ap_dec;
    logic next_ap_valid, next_ap_write;
    tmr8_dec_t next_ap_dec;
    logic [31:0] next_hrdata;
    logic acc;
    tmr8_dec_t dec_now;
    logic [7:0] wdat;

    // ==========================================================
    // Timer state
    logic [7:0] shared_serial_timer_control, next_shared_serial_timer_control;
    logic [7:0] ctrl [TMR8_NCH];
    logic [7:0] csr [TMR8_NCH];
    logic [7:0] tca [TMR8_NCH];
    logic [7:0] tcb [TMR8_NCH];
    logic [7:0] cnt [TMR8_NCH];
    logic [2:0] arm [TMR8_NCH];
    logic int_q [TMR8_NCH];
    logic [7:0] next_ctrl [TMR8_NCH];
    logic [7:0] next_csr [TMR8_NCH];
    logic [7:0] next_tca [TMR8_NCH];
    logic [7:0] next_tcb [TMR8_NCH];
    logic [7:0] next_cnt [TMR8_NCH];
    logic [2:0] next_arm [TMR8_NCH];
    logic next_int_q [TMR8_NCH];
    logic [TMR8_NCH-1:0] next_out, next_irq_a, next_irq_b, next_irq_ov;
    // Per-cycle events, also watched by the checks below
    logic inc [TMR8_NCH];
    logic clr [TMR8_NCH];
    logic eq_a [TMR8_NCH];
    logic eq_b [TMR8_NCH];
    logic ovf_ev [TMR8_NCH];
    logic wr_cnt [TMR8_NCH];
    logic wr_tca [TMR8_NCH];

    // ==========================================================
    // Bus slave: zero wait states, every answer OKAY
    always_comb begin
        dec_now = tmr8_decode(haddr);
        acc = hsel && htrans[HTRANS_ACTIVE] && hready && (hsize == HSIZE_WORD);
        wdat = hwdata[7:0];
        next_ap_valid = acc;
        next_ap_write = acc && hwrite;
        next_ap_dec = acc ? dec_now : '{kind: REG_NONE, ch: 1'b0};
        next_hrdata = hrdata;
        // Read data comes from next values so a write just before is seen
        if (acc && !hwrite) begin
            case (dec_now.kind)
                REG_SHARED_SERIAL_TIMER_CONTROL: next_hrdata = {24'h000000, next_shared_serial_timer_control};
                REG_CTRL: next_hrdata = {24'h000000, next_ctrl[dec_now.ch]};
                REG_CSR: next_hrdata = {24'h000000, next_csr[dec_now.ch]};
                REG_TCA: next_hrdata = {24'h000000, next_tca[dec_now.ch]};
                REG_TCB: next_hrdata = {24'h000000, next_tcb[dec_now.ch]};
                REG_CNT: next_hrdata = {24'h000000, next_cnt[dec_now.ch]};
                default: next_hrdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_dec <= '{kind: REG_NONE, ch: 1'b0};
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            ap_valid <= next_ap_valid;
            ap_write <= next_ap_write;
            ap_dec <= next_ap_dec;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ==========================================================
    // Channel logic; the loop keeps the two channels apart
    always_comb begin
        logic wr, rd_csr, wr_ctrl, wr_csr, wr_tcb, rise, fall, lvl, ext_rst;
        logic [2:0] cks;
        logic [2:0] clr_mask;
        wr = 1'b0;
        rd_csr = 1'b0;
        wr_ctrl = 1'b0;
        wr_csr = 1'b0;
        wr_tcb = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        lvl = 1'b0;
        ext_rst = 1'b0;
        cks = 3'h0;
        clr_mask = 3'h0;
        wr = ap_valid && ap_write;
        next_shared_serial_timer_control = (wr && ap_dec.kind == REG_SHARED_SERIAL_TIMER_CONTROL) ? wdat : shared_serial_timer_control;
        for (int c = 0; c < TMR8_NCH; c++) begin
            wr_ctrl = wr && ap_dec.ch == 1'(c) && ap_dec.kind == REG_CTRL;
            wr_csr = wr && ap_dec.ch == 1'(c) && ap_dec.kind == REG_CSR;
            wr_tca[c] = wr && ap_dec.ch == 1'(c) && ap_dec.kind == REG_TCA;
            wr_tcb = wr && ap_dec.ch == 1'(c) && ap_dec.kind == REG_TCB;
            wr_cnt[c] = wr && ap_dec.ch == 1'(c) && ap_dec.kind == REG_CNT;
            rd_csr = acc && !hwrite && dec_now.ch == 1'(c) && dec_now.kind == REG_CSR;
            // Count pulse: falling edge of the internal level, or pin edges
            cks = ctrl[c][CTRL_CKS_HI:0];
            lvl = tmr8_int_level(1'(c), cks, shared_serial_timer_control[c], div_bus.taps);
            next_int_q[c] = lvl;
            rise = ck_s2[c] && !ck_s3[c];
            fall = !ck_s2[c] && ck_s3[c];
            // Changing the source may itself look like a falling edge
            inc[c] = (int_q[c] && !lvl)
                || (cks == CKS_EXT_RISE && rise)
                || (cks == CKS_EXT_FALL && fall)
                || (cks == CKS_EXT_BOTH && (rise || fall));
            // Compare is blanked in the data phase of a write to that constant
            eq_a[c] = (cnt[c] == tca[c]) && !wr_tca[c];
            eq_b[c] = (cnt[c] == tcb[c]) && !wr_tcb;
            ext_rst = rs_s2[c] && !rs_s3[c];
            case (tmr8_clr_t'(ctrl[c][CTRL_CLR_HI:CTRL_CLR_LO]))
                CLR_NONE: clr[c] = 1'b0;
                CLR_MATCH_A: clr[c] = eq_a[c];
                CLR_MATCH_B: clr[c] = eq_b[c];
                CLR_EXT: clr[c] = ext_rst;
                default: clr[c] = 1'b0;
            endcase
            // Clear beats a bus write, a bus write beats the increment
            if (clr[c]) begin
                next_cnt[c] = CNT_RST;
            end else if (wr_cnt[c]) begin
                next_cnt[c] = wdat;
            end else if (inc[c]) begin
                next_cnt[c] = 8'(cnt[c] + CNT_STEP);
            end else begin
                next_cnt[c] = cnt[c];
            end
            ovf_ev[c] = inc[c] && !clr[c] && !wr_cnt[c] && cnt[c] == CNT_MAX;
            next_ctrl[c] = wr_ctrl ? wdat : ctrl[c];
            next_tca[c] = wr_tca[c] ? wdat : tca[c];
            next_tcb[c] = wr_tcb ? wdat : tcb[c];
            // Zero written to an armed flag clears it; an event in the same
            // cycle still sets it, so no match is lost
            clr_mask = wr_csr ? (~wdat[CSR_FB:CSR_OVF] & arm[c]) : 3'h0;
            next_csr[c][CSR_FB:CSR_OVF] = (csr[c][CSR_FB:CSR_OVF] & ~clr_mask)
                | {eq_b[c], eq_a[c], ovf_ev[c]};
            next_csr[c][CSR_PWM:0] = wr_csr ? wdat[CSR_PWM:0] : csr[c][CSR_PWM:0];
            // Arming happens on a read that sees the flag set
            next_arm[c] = wr_csr ? 3'h0 : arm[c];
            if (rd_csr) begin
                next_arm[c] = next_arm[c] | next_csr[c][CSR_FB:CSR_OVF];
            end
            // Output: PWM level, or actions of match B then match A
            if (csr[c][CSR_PWM]) begin
                next_out[c] = cnt[c] < tca[c];
            end else begin
                next_out[c] = timer_output_pin[c];
                if (eq_b[c]) begin
                    next_out[c] = tmr8_apply(next_out[c], csr[c][CSR_OSB_HI:CSR_OSB_LO]);
                end
                if (eq_a[c]) begin
                    next_out[c] = tmr8_apply(next_out[c], csr[c][CSR_OSA_HI:CSR_OSA_LO]);
                end
            end
            // Standby forces the reset values of the whole channel except the int_q edge flop
            if (standby) begin
                next_cnt[c] = CNT_RST;
                next_ctrl[c] = CTRL_RST;
                next_csr[c] = CSR_RST;
                next_tca[c] = TC_RST;
                next_tcb[c] = TC_RST;
                next_arm[c] = 3'h0;
                next_out[c] = 1'b0;
            end
            next_irq_b[c] = next_csr[c][CSR_FB] && next_ctrl[c][CTRL_IE_B];
            next_irq_a[c] = next_csr[c][CSR_FA] && next_ctrl[c][CTRL_IE_A];
            next_irq_ov[c] = next_csr[c][CSR_OVF] && next_ctrl[c][CTRL_IE_OV];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shared_serial_timer_control <= SHARED_SERIAL_TIMER_CONTROL_RST;
            timer_output_pin <= '0;
            match_a_irq <= '0;
            match_b_irq <= '0;
            overflow_irq <= '0;
            for (int c = 0; c < TMR8_NCH; c++) begin
                ctrl[c] <= CTRL_RST;
                csr[c] <= CSR_RST;
                tca[c] <= TC_RST;
                tcb[c] <= TC_RST;
                cnt[c] <= CNT_RST;
                arm[c] <= 3'h0;
                int_q[c] <= 1'b0;
            end
        end else begin
            shared_serial_timer_control <= next_shared_serial_timer_control;
            timer_output_pin <= next_out;
            match_a_irq <= next_irq_a;
            match_b_irq <= next_irq_b;
            overflow_irq <= next_irq_ov;
            for (int c = 0; c < TMR8_NCH; c++) begin
                ctrl[c] <= next_ctrl[c];
                csr[c] <= next_csr[c];
                tca[c] <= next_tca[c];
                tcb[c] <= next_tcb[c];
                cnt[c] <= next_cnt[c];
                arm[c] <= next_arm[c];
                int_q[c] <= next_int_q[c];
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_standby_clears: assert property (standby |=> cnt[0] == CNT_RST && cnt[1] == CNT_RST)
        else $error("counter not zero after standby");
    a_standby_const: assert property (standby |=> tca[1] == TC_RST && tcb[0] == TC_RST)
        else $error("constant not all ones after standby");
    a_count_step: assert property (inc[0] && !clr[0] && !wr_cnt[0] && !standby
        |=> cnt[0] == 8'($past(cnt[0]) + CNT_STEP))
        else $error("counter did not step by one");
    a_overflow_flag: assert property (cnt[1] == CNT_MAX && inc[1] && !clr[1] && !wr_cnt[1]
        && !standby |=> csr[1][CSR_OVF] && cnt[1] == CNT_RST)
        else $error("rollover did not set overflow flag");
    a_match_a_flag: assert property (cnt[0] == tca[0] && !wr_tca[0] && !standby
        |=> csr[0][CSR_FA])
        else $error("match A did not set its flag");
    a_match_blanked: assert property (wr_tca[0] && !csr[0][CSR_FA] && cnt[0] == tca[0]
        && !standby |=> !csr[0][CSR_FA])
        else $error("match seen during constant write");
    a_clear_on_a: assert property (ctrl[0][CTRL_CLR_HI:CTRL_CLR_LO] == CLR_MATCH_A
        && eq_a[0] |=> cnt[0] == CNT_RST)
        else $error("counter not cleared on match A");
    a_stop_holds: assert property (ctrl[1][CTRL_CKS_HI:0] == CKS_STOP
        && $past(ctrl[1][CTRL_CKS_HI:0]) == CKS_STOP && !clr[1] && !wr_cnt[1] && !standby
        |=> $stable(cnt[1]))
        else $error("stopped counter moved");
    a_cnt_write: assert property (wr_cnt[1] && !clr[1] && !standby
        |=> cnt[1] == $past(hwdata[7:0]))
        else $error("counter write lost");
    a_flag_unarmed: assert property (ap_valid && ap_write && ap_dec.kind == REG_CSR
        && ap_dec.ch == 1'b0 && arm[0] == 3'h0 && !standby
        |=> csr[0][CSR_FB:CSR_OVF] == $past(csr[0][CSR_FB:CSR_OVF])
            || $past(eq_a[0] || eq_b[0] || ovf_ev[0]))
        else $error("unarmed flag changed on write");
    a_irq_b_gate: assert property (match_b_irq[0] == (csr[0][CSR_FB] && ctrl[0][CTRL_IE_B]))
        else $error("match B request not flag and enable");
    a_irq_a_gate: assert property (match_a_irq[1] == (csr[1][CSR_FA] && ctrl[1][CTRL_IE_A]))
        else $error("match A request not flag and enable");
    a_irq_ov_gate: assert property (overflow_irq[0] == (csr[0][CSR_OVF] && ctrl[0][CTRL_IE_OV]))
        else $error("overflow request not flag and enable");
    a_pwm_level: assert property (csr[1][CSR_PWM] && !standby
        |=> timer_output_pin[1] == ($past(cnt[1]) < $past(tca[1])))
        else $error("PWM level wrong");
endmodule

/* File: test/tmr8_pin_model.sv */
// Far-side model of the timer pins: external count clock and counter reset.
// Assumes the bench calls its tasks; pins idle low outside any pulse.
`timescale 1ns/1ps
module tmr8_pin_model import tmr8_pkg::*; (
    input wire logic clk_sys,
    output logic [TMR8_NCH-1:0] cclk,
    output logic [TMR8_NCH-1:0] crst
);
    // ====
    // Idle low; every phase lasts 4 clocks, so the two-flop input never misses it
    initial begin
        cclk = '0;
        crst = '0;
    end
    task automatic count_pulses(input int ch, input int n);
        repeat (n) begin
            repeat (4) @(posedge clk_sys);
            cclk[ch] <= 1'b1;
            repeat (4) @(posedge clk_sys);
            cclk[ch] <= 1'b0;
        end
        repeat (8) @(posedge clk_sys);
    endtask
    // Reset pin rises once; the counter acts on the rising edge only
    task automatic reset_pulse(input int ch);
        @(posedge clk_sys);
        crst[ch] <= 1'b1;
        repeat (4) @(posedge clk_sys);
        crst[ch] <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask
endmodule

/* File: test/tmr8_tb_top.sv */
// Bench for the dual 8-bit timer: bus tasks, pin model and checks.
// Assumes a word-wide AHB-Lite slave; waits end only by the watchdog.
`timescale 1ns/1ps
module tmr8_tb_top import tmr8_pkg::*; ;
    logic clk_sys, rst_n, standby, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [2:0] hsize;
    logic [1:0] htrans;
    logic [TMR8_NCH-1:0] cclk, crst, tpin, irq_a, irq_b, irq_ov;
    int num_errors = 0;
    int samples_checked = 0;
    tmr8_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .standby(standby), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .external_count_clock_pin(cclk), .external_counter_reset_pin(crst),
        .timer_output_pin(tpin), .match_a_irq(irq_a), .match_b_irq(irq_b),
        .overflow_irq(irq_ov));
    tmr8_pin_model pins (.clk_sys(clk_sys), .cclk(cclk), .crst(crst));
    // ====
    // One single word transfer; waits on hready rather than assuming latency
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
        output logic [31:0] rd);
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {14'h0000, idx, 2'h0};
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        htrans <= 2'h0;
        hwdata <= {24'h000000, wd};
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        rd = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, idx, d, r);
    endtask
    task automatic rdc(input logic [15:0] idx, input logic [7:0] e, input string what);
        logic [31:0] r;
        bus(1'b0, idx, 8'h00, r);
        chk(r, {24'h000000, e}, what);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ====
    // Clock, and a watchdog far beyond the few hundred cycles the tests need
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        #200us;
        num_errors++;
        summarize();
    end
    // ====
    // Main sequence
    initial begin
        logic [31:0] r;
        {rst_n, standby, hwrite, htrans, haddr, hwdata} = '0;
        hsel = 1'b1;
        hsize = HSIZE_WORD;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rdc(IDX_SHARED_SERIAL_TIMER_CONTROL, SHARED_SERIAL_TIMER_CONTROL_RST, "shared_serial_timer_control");
        for (int c = 0; c < TMR8_NCH; c++) begin
            rdc(IDX_CTRL[c], CTRL_RST, "ctrl");
            rdc(IDX_CSR[c], CSR_RST, "csr");
            rdc(IDX_TCA[c], TC_RST, "tca");
            rdc(IDX_TCB[c], TC_RST, "tcb");
            rdc(IDX_CNT[c], CNT_RST, "cnt");
        end
        rdc(16'h0100, 8'h00, "unmapped");
        $display("reset test done");
        wr(IDX_TCA[0], 8'h03);
        wr(IDX_CTRL[0], 8'h4D);
        pins.count_pulses(0, 3);
        rdc(IDX_CNT[0], 8'h00, "clr a");
        rdc(IDX_CSR[0], 8'h40, "flag a");
        chk({30'h0, irq_a}, 32'h1, "irq a");
        wr(IDX_CSR[0], 8'h00);
        rdc(IDX_CSR[0], 8'h00, "flag a clr");
        chk({30'h0, irq_a}, 32'h0, "irq a off");
        wr(IDX_TCB[0], 8'h02);
        wr(IDX_CSR[0], 8'h08);
        wr(IDX_CTRL[0], 8'h95);
        pins.count_pulses(0, 2);
        rdc(IDX_CSR[0], 8'h88, "flag b");
        chk({28'h0, tpin, irq_b}, 32'h5, "pin b");
        $display("match test done");
        wr(IDX_CNT[1], 8'hFE);
        wr(IDX_CTRL[1], 8'h25);
        pins.count_pulses(1, 2);
        rdc(IDX_CSR[1], 8'hE0, "ovf");
        chk({28'h0, irq_ov, irq_a}, 32'h8, "irq ov");
        wr(IDX_CTRL[1], 8'h1D);
        wr(IDX_CNT[1], 8'h40);
        rdc(IDX_CNT[1], 8'h40, "cnt wr");
        pins.reset_pulse(1);
        rdc(IDX_CNT[1], 8'h00, "ext clr");
        $display("overflow test done");
        wr(IDX_CTRL[1], 8'h01);
        repeat (80) @(posedge clk_sys);
        bus(1'b0, IDX_CNT[1], 8'h00, r);
        chk({31'h0, r >= 32'd9 && r <= 32'd12}, 32'h1, "div 8");
        wr(IDX_SHARED_SERIAL_TIMER_CONTROL, 8'h1F);
        standby <= 1'b1;
        repeat (2) @(posedge clk_sys);
        standby <= 1'b0;
        rdc(IDX_TCA[0], TC_RST, "sb tca");
        rdc(IDX_CNT[1], CNT_RST, "sb cnt");
        rdc(IDX_SHARED_SERIAL_TIMER_CONTROL, 8'h1F, "sb shared_serial_timer_control");
        chk({30'h0, tpin}, 32'h0, "sb pin");
        $display("clock test done");
        // Stopped counter at zero: constant 0 must give a 0 percent duty level
        wr(IDX_CSR[0], 8'h10);
        wr(IDX_TCA[0], 8'h80);
        rdc(IDX_CSR[0], 8'h10, "pwm mode");
        chk({30'h0, tpin}, 32'h1, "pwm high");
        wr(IDX_TCA[0], 8'h00);
        rdc(IDX_CNT[0], 8'h00, "pwm cnt");
        chk({30'h0, tpin}, 32'h0, "pwm low");
        $display("pwm test done");
        summarize();
    end
endmodule
